/* common/pwt_defs.svh */
`ifndef PWT_DEFS_SVH
`define PWT_DEFS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PWT_OFS_LVCTL 8'h00
`define PWT_OFS_PTCTL 8'h04
`define PWT_OFS_TRIM 8'h08
`define PWT_OFS_RATE 8'h0C
`define PWT_OFS_STAT 8'h10
`define PWT_OFS_MASK 8'h14
// ****************************************
// Field positions
// ****************************************
`define PWT_LV_FLAG 0
`define PWT_LV_IE 1
`define PWT_LV_DET 2
`define PWT_PT_FLAG 0
`define PWT_PT_IE 1
`define PWT_PT_FE 2
`define PWT_PT_OE 3
`define PWT_PT_WS 4
`define PWT_PT_CS 7
`define PWT_TRIM_LSB 2
`define PWT_TRIM_MSB 7
`define PWT_EV_LV 0
`define PWT_EV_PT 1
// ****************************************
// Reset values and timing counts
// ****************************************
`define PWT_RATE_RST 16'h0000
`define PWT_TRIM_RST 6'h00
`define PWT_MASK_RST 2'h0
// Half of the shortest period, in source ticks
`define PWT_PULSE_BUS 2'h1
`define PWT_PULSE_SLOW 2'h2
`endif

/* common/pwt_pkg.sv */
`default_nettype none
package pwt_pkg;
   // Bus answer phase
   typedef enum logic {PWT_BUS_IDLE, PWT_BUS_ANSWER} pwt_bus_t;

   // Whole state of the timer block
   typedef struct packed {
      pwt_bus_t phase;
      logic waitreq;
      logic [31:0] rdata;
      logic lv_det;
      logic lv_flag;
      logic lv_ie;
      logic pt_flag;
      logic pt_ie;
      logic pt_fe;
      logic pt_oe;
      logic pt_ws;
      logic pt_cs;
      logic [15:0] rate;
      logic [5:0] trim;
      logic trim_loaded;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [17:0] cnt;
      logic [1:0] pulse;
      logic tog;
      logic aclk_prev;
      logic wave;
      logic lv_irq;
      logic pt_irq;
      logic irq;
   } pwt_state_t;
endpackage
`default_nettype wire

/* hdl/pwt_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************
module pwt_pin_sync #(
   parameter int WIDTH = 3
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Pins and filtered levels
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } pwt_sync_st_t;

   pwt_sync_st_t st_r;
   pwt_sync_st_t st_nxt;

   // Stage one feeds only stage two; level moves once two and three agree
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (st_r.s2[i] == st_r.s3[i])
         begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign level_out = st_r.q;
endmodule
`default_nettype wire

/* hdl/pwt_timer.sv */
// Functional notes
// - Detect bit reads supply low in full mode
// - Detect change sets flag; write one clears
// - Supply request while flag and enable set
// - Clock select: 0 slow clock, 1 bus
// - Clock select writable only while disabled
// - Feature enable starts timer; clear disables
// - Timeout sets periodic flag; write one clears
// - Periodic request while flag and enable set
// - Wave pin driven only when both enabled
// - Pulse mode: half-minimum-period pulse per timeout
// - Clock mode: toggle once per period
// - Six-bit signed trim in bits 7 to 2
// - Trim loaded from flash after reset
// - Trim bit weights shape slow clock period
// - Period is 2(rate+1) bus cycles or 4(rate+1) slow clock edges
// - Rate writable only while disabled
`timescale 1ns/1ps
`include "pwt_defs.svh"
`default_nettype none
module pwt_timer (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Analog and clock pins
   input wire logic analog_supply_below,
   input wire logic full_performance_mode,
   input wire logic slow_rc_clk,
   // Trim value from flash
   input wire logic [5:0] flash_trim,
   // Outputs
   output logic [5:0] slow_clock_trim_field,
   output logic periodic_wave_out,
   output logic supply_low_irq,
   output logic periodic_irq,
   output logic irq
);
   // ****************************************
   // State and decode helpers
   // ****************************************
   pwt_pkg::pwt_state_t s_r;
   pwt_pkg::pwt_state_t s_nxt;
   logic [2:0] pin_lvl;
   logic det_new;
   logic lv_ev;
   logic pt_ev;
   logic tick;
   logic [17:0] target;

   // Exact match on the full byte address, all eight bits
   function automatic logic pwt_hit(input logic [7:0] addr, input logic [7:0] ofs);
      pwt_hit = (addr == ofs);
   endfunction

   // Read mux over the register map
   function automatic logic [31:0] pwt_rd(input logic [7:0] addr,
                                          input pwt_pkg::pwt_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (pwt_hit(addr, `PWT_OFS_LVCTL))
      begin
         w[`PWT_LV_DET] = s.lv_det;
         w[`PWT_LV_IE] = s.lv_ie;
         w[`PWT_LV_FLAG] = s.lv_flag;
      end
      else if (pwt_hit(addr, `PWT_OFS_PTCTL))
      begin
         w[`PWT_PT_CS] = s.pt_cs;
         w[`PWT_PT_WS] = s.pt_ws;
         w[`PWT_PT_OE] = s.pt_oe;
         w[`PWT_PT_FE] = s.pt_fe;
         w[`PWT_PT_IE] = s.pt_ie;
         w[`PWT_PT_FLAG] = s.pt_flag;
      end
      else if (pwt_hit(addr, `PWT_OFS_TRIM))
      begin
         w[`PWT_TRIM_MSB:`PWT_TRIM_LSB] = s.trim;
      end
      else if (pwt_hit(addr, `PWT_OFS_RATE))
      begin
         w[15:0] = s.rate;
      end
      else if (pwt_hit(addr, `PWT_OFS_STAT))
      begin
         w[1:0] = s.stat;
      end
      else if (pwt_hit(addr, `PWT_OFS_MASK))
      begin
         w[1:0] = s.mask;
      end
      pwt_rd = w;
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   pwt_pin_sync #(
      .WIDTH(3)
   ) u_sync (
      .core_clk(core_clk),
      .reset(reset),
      .pin_in({slow_rc_clk, full_performance_mode, analog_supply_below}),
      .level_out(pin_lvl)
   );

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb
   begin
      s_nxt = s_r;
      lv_ev = 1'b0;
      pt_ev = 1'b0;
      // Detect only counts in full performance mode
      det_new = pin_lvl[0] & pin_lvl[1];
      // Slow ticks on synchronised rising edges; bus ticks every cycle
      s_nxt.aclk_prev = pin_lvl[2];
      tick = s_r.pt_cs ? 1'b1 : (pin_lvl[2] & ~s_r.aclk_prev);
      // Last count of a period: bus 2*rate+1, slow 4*rate+3 edges
      target = s_r.pt_cs ? {1'b0, s_r.rate, 1'b1} : {s_r.rate, 2'b11};

      // Trim caught once after reset release; later writes override
      if (!s_r.trim_loaded)
      begin
         s_nxt.trim = flash_trim;
         s_nxt.trim_loaded = 1'b1;
      end

      // Bus: take in idle, answer one cycle later with waitrequest low
      unique case (s_r.phase)
         pwt_pkg::PWT_BUS_IDLE:
         begin
            if (avs_read || avs_write)
            begin
               s_nxt.phase = pwt_pkg::PWT_BUS_ANSWER;
               s_nxt.waitreq = 1'b0;
               s_nxt.rdata = avs_read ? pwt_rd(avs_address, s_r) : 32'h0000_0000;
            end
         end
         pwt_pkg::PWT_BUS_ANSWER:
         begin
            s_nxt.phase = pwt_pkg::PWT_BUS_IDLE;
            s_nxt.waitreq = 1'b1;
            // Write commits on the edge the master sees waitrequest low
            if (avs_write && avs_byteenable[0])
            begin
               if (pwt_hit(avs_address, `PWT_OFS_LVCTL))
               begin
                  // Detect bit has no write path
                  s_nxt.lv_ie = avs_writedata[`PWT_LV_IE];
                  if (avs_writedata[`PWT_LV_FLAG])
                  begin
                     s_nxt.lv_flag = 1'b0;
                  end
               end
               if (pwt_hit(avs_address, `PWT_OFS_PTCTL))
               begin
                  // Source change while running would corrupt the count
                  if (!s_r.pt_fe && !avs_writedata[`PWT_PT_FE])
                  begin
                     s_nxt.pt_cs = avs_writedata[`PWT_PT_CS];
                  end
                  s_nxt.pt_ws = avs_writedata[`PWT_PT_WS];
                  s_nxt.pt_oe = avs_writedata[`PWT_PT_OE];
                  s_nxt.pt_fe = avs_writedata[`PWT_PT_FE];
                  s_nxt.pt_ie = avs_writedata[`PWT_PT_IE];
                  if (avs_writedata[`PWT_PT_FLAG])
                  begin
                     s_nxt.pt_flag = 1'b0;
                  end
               end
               if (pwt_hit(avs_address, `PWT_OFS_TRIM))
               begin
                  s_nxt.trim = avs_writedata[`PWT_TRIM_MSB:`PWT_TRIM_LSB];
               end
               if (pwt_hit(avs_address, `PWT_OFS_STAT))
               begin
                  s_nxt.stat = s_r.stat & ~avs_writedata[1:0];
               end
               if (pwt_hit(avs_address, `PWT_OFS_MASK))
               begin
                  s_nxt.mask = avs_writedata[1:0];
               end
            end
            // Rate frozen while the timer runs
            if (avs_write && !s_r.pt_fe && pwt_hit(avs_address, `PWT_OFS_RATE))
            begin
               if (avs_byteenable[0])
               begin
                  s_nxt.rate[7:0] = avs_writedata[7:0];
               end
               if (avs_byteenable[1])
               begin
                  s_nxt.rate[15:8] = avs_writedata[15:8];
               end
            end
         end
      endcase

      // Supply detect tracking and change event
      s_nxt.lv_det = det_new;
      lv_ev = (det_new != s_r.lv_det);

      // Period counter; disabled means stopped and cleared
      if (!s_r.pt_fe)
      begin
         s_nxt.cnt = 18'h00000;
         s_nxt.pulse = 2'h0;
         s_nxt.tog = 1'b0;
      end
      else if (tick)
      begin
         if (s_r.cnt == target)
         begin
            s_nxt.cnt = 18'h00000;
            pt_ev = 1'b1;
            s_nxt.pulse = s_r.pt_cs ? `PWT_PULSE_BUS : `PWT_PULSE_SLOW;
            s_nxt.tog = ~s_r.tog;
         end
         else
         begin
            s_nxt.cnt = s_r.cnt + 18'h00001;
            if (s_r.pulse != 2'h0)
            begin
               s_nxt.pulse = s_r.pulse - 2'h1;
            end
         end
      end

      // Events applied after clears so a set always wins
      if (lv_ev)
      begin
         s_nxt.lv_flag = 1'b1;
      end
      if (pt_ev)
      begin
         s_nxt.pt_flag = 1'b1;
      end
      s_nxt.stat = s_nxt.stat | {pt_ev, lv_ev};

      // Registered outputs from the next state
      s_nxt.wave = (s_nxt.pt_fe & s_nxt.pt_oe) &
                   (s_nxt.pt_ws ? s_nxt.tog : (s_nxt.pulse != 2'h0));
      s_nxt.lv_irq = s_nxt.lv_flag & s_nxt.lv_ie;
      s_nxt.pt_irq = s_nxt.pt_flag & s_nxt.pt_ie;
      s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         s_r <= '0;
         s_r.phase <= pwt_pkg::PWT_BUS_IDLE;
         s_r.waitreq <= 1'b1;
         s_r.rate <= `PWT_RATE_RST;
         s_r.trim <= `PWT_TRIM_RST;
         s_r.mask <= `PWT_MASK_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign avs_readdata = s_r.rdata;
   assign avs_waitrequest = s_r.waitreq;
   // Signed trim drives the RC cell; top bit lengthens, lower bits shorten
   assign slow_clock_trim_field = s_r.trim;
   assign periodic_wave_out = s_r.wave;
   assign supply_low_irq = s_r.lv_irq;
   assign periodic_irq = s_r.pt_irq;
   assign irq = s_r.irq;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   AST_LV_DET_TRACKS: assert property (s_r.lv_det == $past(det_new))
      else $error("detect bit does not follow supply input");
   AST_LV_FLAG_SET: assert property (lv_ev |=> s_r.lv_flag)
      else $error("supply change did not set flag");
   AST_LV_IRQ_PAIR: assert property (supply_low_irq == (s_r.lv_flag & s_r.lv_ie))
      else $error("supply request disagrees with flag and enable");
   AST_CS_LOCK: assert property (s_r.pt_fe |=> $stable(s_r.pt_cs))
      else $error("clock select changed while enabled");
   AST_PT_FLAG_SET: assert property (pt_ev |=> s_r.pt_flag && s_r.cnt == 18'h00000)
      else $error("timeout did not set periodic flag");
   AST_WAVE_GATE: assert property (!(s_r.pt_fe && s_r.pt_oe) |-> !periodic_wave_out)
      else $error("wave pin driven while gated off");
   AST_RATE_LOCK: assert property (s_r.pt_fe |=> $stable(s_r.rate))
      else $error("rate changed while enabled");
   AST_STOP_CLEAR: assert property (!s_r.pt_fe |=> s_r.cnt == 18'h00000 && !s_r.tog)
      else $error("disabled timer kept its count");
   AST_BUS_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   // Mode pin low forces the detect bit clear
   AST_LV_DET_RPM: assert property (!pin_lvl[1] |=> !s_r.lv_det)
      else $error("detect bit set outside full performance mode");
   // Flags fall only through a committed write of one
   AST_LV_FLAG_STICKY: assert property (
      s_r.lv_flag && !(s_r.phase == pwt_pkg::PWT_BUS_ANSWER && avs_write &&
      avs_byteenable[0] && avs_address == `PWT_OFS_LVCTL && avs_writedata[`PWT_LV_FLAG])
      |=> s_r.lv_flag)
      else $error("supply flag fell without a clear");
   AST_PT_FLAG_STICKY: assert property (
      s_r.pt_flag && !(s_r.phase == pwt_pkg::PWT_BUS_ANSWER && avs_write &&
      avs_byteenable[0] && avs_address == `PWT_OFS_PTCTL && avs_writedata[`PWT_PT_FLAG])
      |=> s_r.pt_flag)
      else $error("periodic flag fell without a clear");
   AST_PT_IRQ_PAIR: assert property (periodic_irq == (s_r.pt_flag & s_r.pt_ie))
      else $error("periodic request disagrees with flag and enable");
   // Enabling write must not move the source select
   AST_CS_SAME_WRITE: assert property (
      s_r.phase == pwt_pkg::PWT_BUS_ANSWER && avs_write && avs_address == `PWT_OFS_PTCTL &&
      avs_writedata[`PWT_PT_FE] |=> $stable(s_r.pt_cs))
      else $error("clock select moved by enabling write");
   // Counter steps by one on each non-final tick
   AST_CNT_STEP: assert property (
      s_r.pt_fe && tick && s_r.cnt != target |=> s_r.cnt == $past(s_r.cnt) + 18'h00001)
      else $error("period counter did not advance");
   AST_TOG_FLIP: assert property (pt_ev |=> s_r.tog != $past(s_r.tog))
      else $error("clock wave did not toggle at timeout");
   AST_STAT_LV_WINS: assert property (lv_ev |=> s_r.stat[`PWT_EV_LV])
      else $error("supply status bit lost to a clear");
   AST_STAT_PT_WINS: assert property (pt_ev |=> s_r.stat[`PWT_EV_PT])
      else $error("timeout status bit lost to a clear");
   // Flash value lands on the first edge after reset
   AST_TRIM_LOAD: assert property (
      $rose(s_r.trim_loaded) |-> s_r.trim == $past(flash_trim))
      else $error("trim not loaded from flash");
endmodule
`default_nettype wire

/* sim/pwt_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// *******
// Supply pins, slow oscillator and flash
// *******
module pwt_far_model #(
   parameter int HALF = 3,
   parameter logic [5:0] TRIM = 6'h2D
) (
   // Clock and bench controls
   input wire logic core_clk,
   input wire logic low_req,
   input wire logic fpm_req,
   // Pins toward the block
   output logic analog_supply_below,
   output logic full_performance_mode,
   output logic slow_rc_clk,
   output logic [5:0] flash_trim
);
   int n = 0;
   logic osc = 1'b0;
   // Free-running oscillator, locked to core_clk so periods are exact
   always @(posedge core_clk)
   begin
      n <= (n == HALF - 1) ? 0 : n + 1;
      if (n == HALF - 1)
         osc <= ~osc;
   end
   // Single driver for the clock pin
   assign slow_rc_clk = osc;
   // Supply comparator and mode pins follow the bench
   assign analog_supply_below = low_req;
   assign full_performance_mode = fpm_req;
   assign flash_trim = TRIM; // Factory value, arbitrary
endmodule
`default_nettype wire

/* sim/tb_pwt_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwt_defs.svh"
module tb_pwt_timer;
   localparam int HALF = 3;
   localparam logic [5:0] TRIM = 6'h2D;
   localparam int LIMIT = 30000;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, wave_q;
   logic low_req = 1'b0;
   logic fpm_req = 1'b1;
   logic analog_supply_below, full_performance_mode, slow_rc_clk;
   logic [5:0] flash_trim, slow_clock_trim_field;
   logic periodic_wave_out, supply_low_irq, periodic_irq, irq;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   int rise_at = 0;
   int rise_gap = 0;
   int hi_len = 0;

   pwt_timer dut_u (.core_clk, .reset, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
      .analog_supply_below, .full_performance_mode, .slow_rc_clk, .flash_trim,
      .slow_clock_trim_field, .periodic_wave_out, .supply_low_irq, .periodic_irq, .irq);
   pwt_far_model #(.HALF(HALF), .TRIM(TRIM)) far_u (.core_clk, .low_req, .fpm_req,
      .analog_supply_below, .full_performance_mode, .slow_rc_clk, .flash_trim);

   // Clock
   initial
   begin
      forever #4 core_clk = ~core_clk;
   end

   // *******
   // Tasks
   // *******
   task automatic wrap_up;
      if (n_mismatch == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Expected period in core cycles for a source and a rate
   function automatic int exp_period(input logic cs, input int r);
      exp_period = cs ? 2 * (r + 1) : 8 * HALF * (r + 1);
   endfunction

   // One bus cycle; two idle edges after so registered outputs settle
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      avs_write <= wr;
      avs_read <= ~wr;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge core_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   // Wave edge timing and hang guard
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      wave_q <= periodic_wave_out;
      if (periodic_wave_out === 1'b1 && wave_q === 1'b0)
      begin
         rise_gap <= cyc - rise_at;
         rise_at <= cyc;
      end
      if (periodic_wave_out === 1'b0 && wave_q === 1'b1)
         hi_len <= cyc - rise_at;
      if (cyc == LIMIT)
      begin
         n_mismatch++;
         wrap_up();
      end
   end

   // *******
   // Main sequence
   // *******
   initial
   begin
      int r, p, t, ra;
      logic cs, ws;
      void'($urandom(41198));
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      // Trim from flash, then a random write
      bus(1'b0, `PWT_OFS_TRIM, 32'h0);
      chk("trim", 32'(q[7:2]), 32'(TRIM));
      chk("trim_pin", 32'(slow_clock_trim_field), 32'(TRIM));
      t = $urandom_range(0, 63);
      bus(1'b1, `PWT_OFS_TRIM, 32'(t) << 2);
      bus(1'b0, `PWT_OFS_TRIM, 32'h0);
      chk("trim_wr", 32'(q[7:2]), t);
      chk("trim_pin_wr", 32'(slow_clock_trim_field), t);
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped", q, 32'h0);
      // Supply drops in full mode; writing zero to flag keeps it
      low_req <= 1'b1;
      repeat (10) @(posedge core_clk);
      bus(1'b1, `PWT_OFS_LVCTL, 32'h2);
      bus(1'b0, `PWT_OFS_LVCTL, 32'h0);
      chk("lvctl", 32'(q[2:0]), 32'h7);
      chk("lv_irq", 32'(supply_low_irq), 32'h1);
      bus(1'b1, `PWT_OFS_LVCTL, 32'h5);
      bus(1'b0, `PWT_OFS_LVCTL, 32'h0);
      chk("lvctl_clr", 32'(q[2:0]), 32'h4);
      chk("lv_irq_clr", 32'(supply_low_irq), 32'h0);
      // Reduced mode reads not-low, which is itself a change
      fpm_req <= 1'b0;
      repeat (10) @(posedge core_clk);
      bus(1'b0, `PWT_OFS_LVCTL, 32'h0);
      chk("lvctl_rpm", 32'(q[2:0]), 32'h1);
      chk("lv_irq_off", 32'(supply_low_irq), 32'h0);
      // Summary interrupt: unmask, mask, unmask, clear
      bus(1'b1, `PWT_OFS_MASK, 32'h1);
      chk("irq_on", 32'(irq), 32'h1);
      bus(1'b1, `PWT_OFS_MASK, 32'h0);
      chk("irq_masked", 32'(irq), 32'h0);
      bus(1'b1, `PWT_OFS_MASK, 32'h1);
      bus(1'b1, `PWT_OFS_STAT, 32'h1);
      chk("irq_clr", 32'(irq), 32'h0);
      // Both sources, both waveforms; enable write also tries to flip select
      for (int i = 0; i < 4; i++)
      begin
         cs = i[0];
         ws = i[1];
         r = (i == 0) ? 0 : $urandom_range(1, 3);
         p = exp_period(cs, r);
         bus(1'b1, `PWT_OFS_RATE, 32'(r));
         bus(1'b1, `PWT_OFS_PTCTL, {24'h0, cs, 7'h00});
         bus(1'b1, `PWT_OFS_PTCTL, {24'h0, ~cs, 2'b00, ws, 4'hE});
         repeat (7 * p) @(posedge core_clk);
         chk("gap", rise_gap, ws ? 2 * p : p);
         chk("high", hi_len, ws ? p : (cs ? 1 : 4 * HALF));
         chk("pt_irq", 32'(periodic_irq), 32'h1);
         bus(1'b1, `PWT_OFS_RATE, 32'(r + 5));
         bus(1'b0, `PWT_OFS_RATE, 32'h0);
         chk("rate", 32'(q[15:0]), r);
         bus(1'b0, `PWT_OFS_PTCTL, 32'h0);
         chk("ptctl", 32'(q[7:0]), {24'h0, cs, 2'b00, ws, 4'hF});
         bus(1'b1, `PWT_OFS_PTCTL, 32'h0);
         bus(1'b1, `PWT_OFS_PTCTL, 32'h1);
         repeat (3 * p) @(posedge core_clk);
         bus(1'b0, `PWT_OFS_PTCTL, 32'h0);
         chk("pt_off", 32'(q[0]), 32'h0);
         chk("pt_irq_off", 32'(periodic_irq), 32'h0);
         chk("wave_off", 32'(periodic_wave_out), 32'h0);
      end
      // Timer runs with the pin disabled: no wave, flag still raised
      // Select bit in the enabling write is ignored, so the slow source runs
      bus(1'b1, `PWT_OFS_PTCTL, 32'h86);
      ra = rise_at;
      repeat (2 * exp_period(1'b0, r)) @(posedge core_clk);
      chk("no_wave", rise_at, ra);
      chk("wave_nopin", 32'(periodic_wave_out), 32'h0);
      chk("pt_irq_nopin", 32'(periodic_irq), 32'h1);
      bus(1'b0, `PWT_OFS_PTCTL, 32'h0);
      chk("ptctl_lock", 32'(q[7:0]), 32'h07);
      // Mid-run reset: control clears, flash trim comes back
      bus(1'b1, `PWT_OFS_TRIM, {24'h0, ~TRIM, 2'b00});
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      bus(1'b0, `PWT_OFS_TRIM, 32'h0);
      chk("trim_reload", 32'(q[7:2]), 32'(TRIM));
      bus(1'b0, `PWT_OFS_PTCTL, 32'h0);
      chk("ptctl_rst", q, 32'h0);
      chk("pt_irq_rst", 32'(periodic_irq), 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
